// ### hw/sfrp_array.sv
`timescale 1ns/10ps
module sfrp_array #(
    parameter int AW = 24,
    parameter int DW = 8
) (
    // clock
    input wire logic clk,
    // preload port
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [DW-1:0] wr_data,
    // read port, one cycle latency
    input wire logic rd_en,
    input wire logic [AW-1:0] rd_addr,
    output logic [DW-1:0] rd_data
);
    logic [DW-1:0] cell_reg [2**AW];

    always_ff @(posedge clk) begin
        if (wr_en) begin
            cell_reg[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge clk) begin
        if (rd_en) begin
            rd_data <= cell_reg[rd_addr];
        end
    end
endmodule

// ### hw/sfrp_fifo.sv
`timescale 1ns/10ps
module sfrp_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic flush,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [PW-1:0] wr_ptr_reg;
    logic [PW-1:0] rd_ptr_reg;
    logic [PW:0] count_reg;
    logic push;
    logic pop;

    assign in_ready = (count_reg != (PW+1)'(DEPTH));
    assign out_valid = (count_reg != '0);
    assign out_data = mem_reg[rd_ptr_reg];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge clk) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= in_data;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end else if (flush) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= wr_ptr_reg + PW'(1);
            end
            if (pop) begin
                rd_ptr_reg <= rd_ptr_reg + PW'(1);
            end
            if (push && !pop) begin
                count_reg <= count_reg + (PW+1)'(1);
            end else if (pop && !push) begin
                count_reg <= count_reg - (PW+1)'(1);
            end
        end
    end
endmodule

// ### hw/sfrp_pkg.sv
package sfrp_pkg;

    // ------------------------------------------------------------
    // array and frame geometry
    // ------------------------------------------------------------
    localparam int ADDR_W = 24;
    localparam int BYTE_W = 8;
    localparam int FIFO_DEPTH = 16;
    localparam logic [4:0] CMD_BITS = 5'd8;
    localparam logic [4:0] ADDR_BITS = 5'd24;
    localparam logic [3:0] LANE_IDLE_VAL = 4'h0;
    localparam logic [7:0] EMPTY_BYTE = 8'hff;

    // ------------------------------------------------------------
    // read command codes
    // ------------------------------------------------------------
    localparam logic [7:0] CMD_READ = 8'h03;
    localparam logic [7:0] CMD_FAST = 8'h0b;
    localparam logic [7:0] CMD_DUAL_OUT = 8'h3b;
    localparam logic [7:0] CMD_DUAL_IO = 8'hbb;
    localparam logic [7:0] CMD_QUAD_OUT = 8'h6b;
    localparam logic [7:0] CMD_QUAD_IO = 8'heb;

    // ------------------------------------------------------------
    // dummy clock counts
    // ------------------------------------------------------------
    localparam logic [4:0] DUMMY_READ = 5'd0;
    localparam logic [4:0] DUMMY_FAST = 5'd8;
    localparam logic [4:0] DUMMY_DUAL_OUT = 5'd8;
    localparam logic [4:0] DUMMY_DUAL_IO = 5'd8;
    localparam logic [4:0] DUMMY_QUAD_OUT = 5'd8;
    localparam logic [4:0] DUMMY_QUAD_IO = 5'd10;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int SYNC_STAGES = 2;

    // lane width code: number of lanes is 1 << code
    typedef logic [1:0] sfrp_lw_t;
    localparam sfrp_lw_t LW_ONE = 2'd0;
    localparam sfrp_lw_t LW_TWO = 2'd1;
    localparam sfrp_lw_t LW_FOUR = 2'd2;

    typedef enum logic [1:0] {
        SFRP_PROTO_EXT = 2'b00,
        SFRP_PROTO_DUAL = 2'b01,
        SFRP_PROTO_QUAD = 2'b10
    } sfrp_proto_e;

    typedef enum logic [2:0] {
        SFRP_IDLE = 3'b000,
        SFRP_CMD = 3'b001,
        SFRP_ADDR = 3'b011,
        SFRP_DUMMY = 3'b010,
        SFRP_DATA = 3'b110,
        SFRP_IGNORE = 3'b111
    } sfrp_state_e;

endpackage

// ### hw/sfrp_read_path.sv
`timescale 1ns/10ps
module sfrp_read_path
    import sfrp_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // serial link pins
    input wire logic serial_clk,
    input wire logic chip_sel_n,
    input wire logic [3:0] serial_io_lanes_in,
    output logic [3:0] serial_io_lanes_out,
    output logic [3:0] serial_io_lanes_oe,
    // protocol strap
    input wire logic [1:0] proto_sel,
    // array preload
    input wire logic load_en,
    input wire logic [ADDR_W-1:0] load_addr,
    input wire logic [BYTE_W-1:0] load_data,
    // status
    output logic read_active
);

    // ------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------
    function automatic logic cmd_allowed(input logic [7:0] c, input logic [1:0] p);
        logic ok;
        ok = 1'b0;
        case (c)
            CMD_READ: ok = (p == SFRP_PROTO_EXT);
            CMD_FAST: ok = (p == SFRP_PROTO_EXT) || (p == SFRP_PROTO_DUAL) || (p == SFRP_PROTO_QUAD);
            CMD_DUAL_OUT, CMD_DUAL_IO: ok = (p == SFRP_PROTO_EXT) || (p == SFRP_PROTO_DUAL);
            CMD_QUAD_OUT, CMD_QUAD_IO: ok = (p == SFRP_PROTO_EXT) || (p == SFRP_PROTO_QUAD);
            default: ok = 1'b0;
        endcase
        return ok;
    endfunction
    function automatic sfrp_lw_t proto_lw(input logic [1:0] p);
        sfrp_lw_t lw;
        lw = LW_ONE;
        case (p)
            SFRP_PROTO_DUAL: lw = LW_TWO;
            SFRP_PROTO_QUAD: lw = LW_FOUR;
            default: lw = LW_ONE;
        endcase
        return lw;
    endfunction
    // lanes in dual and quad protocols follow the protocol for every phase
    function automatic sfrp_lw_t addr_lw(input logic [7:0] c, input logic [1:0] p);
        sfrp_lw_t lw;
        lw = proto_lw(p);
        if (p == SFRP_PROTO_EXT) begin
            case (c)
                CMD_DUAL_IO: lw = LW_TWO;
                CMD_QUAD_IO: lw = LW_FOUR;
                default: lw = LW_ONE;
            endcase
        end
        return lw;
    endfunction
    function automatic sfrp_lw_t data_lw(input logic [7:0] c, input logic [1:0] p);
        sfrp_lw_t lw;
        lw = proto_lw(p);
        if (p == SFRP_PROTO_EXT) begin
            case (c)
                CMD_DUAL_OUT, CMD_DUAL_IO: lw = LW_TWO;
                CMD_QUAD_OUT, CMD_QUAD_IO: lw = LW_FOUR;
                default: lw = LW_ONE;
            endcase
        end
        return lw;
    endfunction
    function automatic logic [4:0] dummy_count(input logic [7:0] c);
        logic [4:0] n;
        n = DUMMY_READ;
        case (c)
            CMD_FAST: n = DUMMY_FAST;
            CMD_DUAL_OUT: n = DUMMY_DUAL_OUT;
            CMD_DUAL_IO: n = DUMMY_DUAL_IO;
            CMD_QUAD_OUT: n = DUMMY_QUAD_OUT;
            CMD_QUAD_IO: n = DUMMY_QUAD_IO;
            default: n = DUMMY_READ;
        endcase
        return n;
    endfunction
    // one edge of input bits shifted in, msb first
    function automatic logic [23:0] shift_in(input logic [23:0] v, input logic [3:0] l,
                                             input sfrp_lw_t lw);
        logic [23:0] r;
        r = {v[22:0], l[0]};
        case (lw)
            LW_TWO: r = {v[21:0], l[1:0]};
            LW_FOUR: r = {v[19:0], l[3:0]};
            default: r = {v[22:0], l[0]};
        endcase
        return r;
    endfunction
    function automatic logic [3:0] lane_bits(input logic [7:0] b, input sfrp_lw_t lw);
        logic [3:0] r;
        r = {2'b00, b[7], 1'b0};
        case (lw)
            LW_TWO: r = {2'b00, b[7:6]};
            LW_FOUR: r = b[7:4];
            default: r = {2'b00, b[7], 1'b0};
        endcase
        return r;
    endfunction
    function automatic logic [3:0] lane_enables(input sfrp_lw_t lw);
        logic [3:0] r;
        r = 4'h2;
        case (lw)
            LW_TWO: r = 4'h3;
            LW_FOUR: r = 4'hf;
            default: r = 4'h2;
        endcase
        return r;
    endfunction

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [7:0] meta_reg, sync_reg;
    logic sclk_prev_reg, sclk_rise, sclk_fall, sel_low;
    logic [3:0] lanes_s;
    logic [1:0] proto_s;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            meta_reg <= 8'h02;
            sync_reg <= 8'h02;
            sclk_prev_reg <= 1'b0;
        end else begin
            meta_reg <= {proto_sel, serial_io_lanes_in, chip_sel_n, serial_clk};
            sync_reg <= meta_reg;
            sclk_prev_reg <= sync_reg[0];
        end
    end

    assign sel_low = !sync_reg[1];
    assign lanes_s = sync_reg[5:2];
    assign proto_s = sync_reg[7:6];
    assign sclk_rise = sync_reg[0] && !sclk_prev_reg;
    assign sclk_fall = !sync_reg[0] && sclk_prev_reg;

    // ------------------------------------------------------------
    // frame sequencer
    // ------------------------------------------------------------
    sfrp_state_e state_reg;
    logic [1:0] proto_reg;
    logic [23:0] shift_reg, shift_next;
    logic [4:0] cnt_reg, dummy_reg, phase_edges;
    sfrp_lw_t in_lw_reg, out_lw_reg;
    logic last_edge, addr_done;

    assign shift_next = shift_in(shift_reg, lanes_s, in_lw_reg);
    assign phase_edges = (state_reg == SFRP_CMD) ? (CMD_BITS >> in_lw_reg)
        : (state_reg == SFRP_ADDR) ? (ADDR_BITS >> in_lw_reg) : dummy_reg;
    assign last_edge = sclk_rise && (cnt_reg == phase_edges - 5'd1);
    assign addr_done = (state_reg == SFRP_ADDR) && last_edge;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg <= SFRP_IDLE;
            proto_reg <= SFRP_PROTO_EXT;
            shift_reg <= 24'h000000;
            cnt_reg <= 5'd0;
            dummy_reg <= 5'd0;
            in_lw_reg <= LW_ONE;
            out_lw_reg <= LW_ONE;
        end else if (!sel_low) begin
            state_reg <= SFRP_IDLE;
            proto_reg <= proto_s;
            in_lw_reg <= proto_lw(proto_s);
            cnt_reg <= 5'd0;
            shift_reg <= 24'h000000;
        end else begin
            case (state_reg)
                SFRP_IDLE: state_reg <= SFRP_CMD;
                SFRP_CMD: begin
                    if (sclk_rise) begin
                        shift_reg <= shift_next;
                        cnt_reg <= cnt_reg + 5'd1;
                    end
                    if (last_edge) begin
                        cnt_reg <= 5'd0;
                        // unknown or disallowed codes sit out the frame
                        if (cmd_allowed(shift_next[7:0], proto_reg)) begin
                            // only lane counts depend on protocol
                            state_reg <= SFRP_ADDR;
                            in_lw_reg <= addr_lw(shift_next[7:0], proto_reg);
                            out_lw_reg <= data_lw(shift_next[7:0], proto_reg);
                            dummy_reg <= dummy_count(shift_next[7:0]);
                        end else begin
                            state_reg <= SFRP_IGNORE;
                        end
                    end
                end
                SFRP_ADDR: begin
                    if (sclk_rise) begin
                        shift_reg <= shift_next;
                        cnt_reg <= cnt_reg + 5'd1;
                    end
                    if (last_edge) begin
                        cnt_reg <= 5'd0;
                        // no wait when the count is zero
                        state_reg <= (dummy_reg == 5'd0) ? SFRP_DATA : SFRP_DUMMY;
                    end
                end
                SFRP_DUMMY: begin
                    if (sclk_rise) begin
                        cnt_reg <= cnt_reg + 5'd1;
                    end
                    if (last_edge) begin
                        state_reg <= SFRP_DATA;
                    end
                end
                SFRP_DATA: state_reg <= SFRP_DATA;
                SFRP_IGNORE: state_reg <= SFRP_IGNORE;
                default: state_reg <= SFRP_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // array prefetch into the byte queue
    // ------------------------------------------------------------
    logic [ADDR_W-1:0] fetch_addr_reg;
    logic fetch_on_reg, pend_reg, rd_go;
    logic [BYTE_W-1:0] rd_byte, q_byte;
    logic q_in_ready, q_out_valid, q_pop;

    // single read in flight, so the queue cannot fill behind our back
    assign rd_go = fetch_on_reg && !pend_reg && q_in_ready && sel_low;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            fetch_addr_reg <= '0;
            fetch_on_reg <= 1'b0;
            pend_reg <= 1'b0;
        end else if (!sel_low) begin
            fetch_on_reg <= 1'b0;
            pend_reg <= 1'b0;
        end else begin
            pend_reg <= rd_go;
            if (addr_done) begin
                fetch_addr_reg <= shift_next[ADDR_W-1:0];
                fetch_on_reg <= 1'b1;
            end else if (rd_go) begin
                // next byte address, wraps at top
                fetch_addr_reg <= fetch_addr_reg + ADDR_W'(1);
            end
        end
    end

    sfrp_array #(
        .AW(ADDR_W),
        .DW(BYTE_W)
    ) u_array (
        .clk(clk),
        .wr_en(load_en),
        .wr_addr(load_addr),
        .wr_data(load_data),
        .rd_en(rd_go),
        .rd_addr(fetch_addr_reg),
        .rd_data(rd_byte)
    );

    sfrp_fifo #(
        .WIDTH(BYTE_W),
        .DEPTH(FIFO_DEPTH)
    ) u_queue (
        .clk(clk),
        .sys_rst(sys_rst),
        .flush(!sel_low),
        .in_valid(pend_reg),
        .in_ready(q_in_ready),
        .in_data(rd_byte),
        .out_valid(q_out_valid),
        .out_ready(q_pop),
        .out_data(q_byte)
    );

    // ------------------------------------------------------------
    // data shifter, changes on falling edges
    // ------------------------------------------------------------
    logic [7:0] out_sh_reg, byte_now, shifted;
    logic [2:0] left_reg, left_next;

    assign q_pop = (state_reg == SFRP_DATA) && sel_low && sclk_fall && (left_reg == 3'd0);
    // queue runs far ahead of the link, empty only under a broken clock
    assign byte_now = q_out_valid ? q_byte : EMPTY_BYTE;
    assign shifted = out_sh_reg << (3'd1 << out_lw_reg);
    assign left_next = 3'((4'd8 >> out_lw_reg) - 4'd1);

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            out_sh_reg <= 8'h00;
            left_reg <= 3'd0;
            serial_io_lanes_out <= LANE_IDLE_VAL;
            serial_io_lanes_oe <= 4'h0;
            read_active <= 1'b0;
        end else if (!sel_low || state_reg != SFRP_DATA) begin
            // drive dropped once select is seen high
            // ignored frames never reach data phase
            left_reg <= 3'd0;
            serial_io_lanes_out <= LANE_IDLE_VAL;
            serial_io_lanes_oe <= 4'h0;
            read_active <= sel_low && (state_reg != SFRP_IDLE)
                && (state_reg != SFRP_IGNORE);
        end else begin
            read_active <= 1'b1;
            if (sclk_fall) begin
                // single lane data leaves on lane one
                serial_io_lanes_oe <= lane_enables(out_lw_reg);
                if (left_reg == 3'd0) begin
                    // next queued byte follows at once
                    out_sh_reg <= byte_now;
                    left_reg <= left_next;
                    serial_io_lanes_out <= lane_bits(byte_now, out_lw_reg);
                end else begin
                    out_sh_reg <= shifted;
                    left_reg <= left_reg - 3'd1;
                    serial_io_lanes_out <= lane_bits(shifted, out_lw_reg);
                end
            end
        end
    end

endmodule

// ### tb/sfrp_host_model.sv
`timescale 1ns/10ps
module sfrp_host_model (
    // link pins toward the device
    output logic serial_clk,
    output logic chip_sel_n,
    output logic [3:0] host_lanes,
    // resolved wire levels
    input wire logic [3:0] wire_lanes
);
    logic [7:0] got_q[$];
    initial begin
        serial_clk = 1'b0;
        chip_sel_n = 1'b1;
        host_lanes = 4'h0;
    end
    function automatic logic [3:0] pick(input logic [23:0] v, input int i, w);
        return 4'((v >> i) & ((24'h1 << w) - 24'h1));
    endfunction
    task automatic tick(input logic [3:0] drv, output logic [3:0] smp);
        serial_clk = 1'b0;
        host_lanes = drv;
        #62.5;
        serial_clk = 1'b1;
        smp = wire_lanes;
        #62.5;
    endtask
    task automatic frame(input int cw, aw, dw, nd, nb, input logic [7:0] cmd,
                         input logic [23:0] addr);
        logic [3:0] s;
        logic [7:0] b;
        int i;
        got_q.delete();
        chip_sel_n = 1'b0;
        #62.5;
        for (i = 8 - cw; i >= 0; i -= cw) tick(pick({16'h0, cmd}, i, cw), s);
        for (i = 24 - aw; i >= 0; i -= aw) tick(pick(addr, i, aw), s);
        // released lanes toggle so stale levels never look valid
        repeat (nd) tick(~host_lanes, s);
        repeat (nb) begin
            for (i = 0; i < 8; i += dw) begin
                tick(~host_lanes, s);
                b = (b << dw) | (8'(dw == 1 ? s[1] : s) & 8'((1 << dw) - 1));
            end
            got_q.push_back(b);
        end
        serial_clk = 1'b0;
        #62.5;
        chip_sel_n = 1'b1;
    endtask
endmodule

// ### tb/sfrp_read_path_monitor.sv
`timescale 1ns/10ps
module sfrp_read_path_monitor
    import sfrp_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // link pins
    input wire logic serial_clk,
    input wire logic chip_sel_n,
    input wire logic [3:0] serial_io_lanes_in,
    input wire logic [3:0] serial_io_lanes_out,
    input wire logic [3:0] serial_io_lanes_oe,
    // strap, preload, status
    input wire logic [1:0] proto_sel,
    input wire logic load_en,
    input wire logic [ADDR_W-1:0] load_addr,
    input wire logic [BYTE_W-1:0] load_data,
    input wire logic read_active
);
    logic sclk_reg;
    logic [3:0] fall_cnt_reg;
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    // cycles since the link clock pin fell, saturating
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            sclk_reg <= 1'b0;
            fall_cnt_reg <= 4'hf;
        end else begin
            sclk_reg <= serial_clk;
            if (sclk_reg && !serial_clk) begin
                fall_cnt_reg <= 4'h0;
            end else if (fall_cnt_reg != 4'hf) begin
                fall_cnt_reg <= fall_cnt_reg + 4'h1;
            end
        end
    end
    oe_width_a: assert property (serial_io_lanes_oe inside {4'h0, 4'h2, 4'h3, 4'hf})
        else $error("illegal lane enable pattern");
    stop_drive_a: assert property ($rose(chip_sel_n) |-> ##[0:5] serial_io_lanes_oe == 4'h0)
        else $error("lanes driven after deselect");
    idle_quiet_a: assert property (chip_sel_n [*6] |-> !read_active && !serial_io_lanes_oe)
        else $error("busy while deselected");
    oe_steady_a: assert property ($changed(serial_io_lanes_oe) |->
        $past(serial_io_lanes_oe) == 4'h0 || serial_io_lanes_oe == 4'h0)
        else $error("lane width changed in frame");
    proto_lanes_a: assert property ($rose(|serial_io_lanes_oe) |-> proto_sel == 2'b00 ||
        serial_io_lanes_oe == (proto_sel == 2'b01 ? 4'h3 : 4'hf))
        else $error("lane width wrong for protocol");
    refuse_proto_a: assert property ($rose(|serial_io_lanes_oe) |-> proto_sel != 2'b11)
        else $error("driven with no protocol");
    first_bit_a: assert property ($rose(|serial_io_lanes_oe) |-> read_active && fall_cnt_reg < 4'h8)
        else $error("first data not after a clock fall");
    shift_fall_a: assert property ($changed(serial_io_lanes_out) && |serial_io_lanes_oe &&
        $past(|serial_io_lanes_oe) |-> fall_cnt_reg < 4'h8)
        else $error("data moved away from a clock fall");
endmodule
bind sfrp_read_path sfrp_read_path_monitor mon (.clk, .sys_rst, .serial_clk, .chip_sel_n,
    .serial_io_lanes_in, .serial_io_lanes_out, .serial_io_lanes_oe, .proto_sel, .load_en,
    .load_addr, .load_data, .read_active);

// ### tb/sfrp_read_path_test.sv
`timescale 1ns/10ps
module sfrp_read_path_test
    import sfrp_pkg::*;
;
    logic clk, sys_rst, serial_clk, chip_sel_n, load_en, read_active;
    logic [3:0] lanes_out, lanes_oe, host_lanes, wire_lanes;
    logic [1:0] proto_sel;
    logic [23:0] load_addr;
    logic [7:0] load_data;
    logic [7:0] mem[int];
    logic [7:0] cmds[6] = '{8'h03, 8'h0b, 8'h3b, 8'hbb, 8'h6b, 8'heb};
    int error_cnt, tests_run, cyc, oe_seen;
    sfrp_read_path dut (.clk, .sys_rst, .serial_clk, .chip_sel_n,
        .serial_io_lanes_in(wire_lanes), .serial_io_lanes_out(lanes_out),
        .serial_io_lanes_oe(lanes_oe), .proto_sel, .load_en, .load_addr, .load_data,
        .read_active);
    sfrp_host_model host (.serial_clk, .chip_sel_n, .host_lanes, .wire_lanes);
    assign wire_lanes = (lanes_oe & lanes_out) | (~lanes_oe & host_lanes);
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (|lanes_oe) oe_seen = 1;
        if (cyc == 90000) begin
            error_cnt++;
            complete_run();
        end
    end
    task automatic check(input logic [7:0] got, exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic load(input logic [23:0] a);
        @(posedge clk) #1;
        load_en = 1'b1;
        load_addr = a;
        load_data = 8'($urandom);
        mem[a] = load_data;
        @(posedge clk) #1;
        load_en = 1'b0;
    endtask
    // ------------------------------------------------------------
    // reference: lanes, dummies and legality per protocol
    // ------------------------------------------------------------
    task automatic run(input int p, input logic [7:0] c, input logic [23:0] a);
        int cw, aw, dw, nd, ok, i;
        cw = p == 1 ? 2 : p == 2 ? 4 : 1;
        aw = p != 0 ? cw : c == 8'hbb ? 2 : c == 8'heb ? 4 : 1;
        dw = p != 0 ? cw : c inside {8'h3b, 8'hbb} ? 2 : c inside {8'h6b, 8'heb} ? 4 : 1;
        nd = c == 8'heb ? 10 : c == 8'h03 ? 0 : 8;
        ok = p == 0 ? 1 : p == 1 ? c inside {8'h0b, 8'h3b, 8'hbb} :
             p == 2 ? c inside {8'h0b, 8'h6b, 8'heb} : 0;
        for (i = 0; i < 3; i++) load(a + 24'(i));
        @(posedge clk) #1;
        proto_sel = 2'(p);
        repeat (8) @(posedge clk);
        oe_seen = 0;
        host.frame(cw, aw, dw, nd, 3, c, a);
        repeat (8) @(posedge clk);
        if (ok) begin
            for (i = 0; i < 3; i++) check(host.got_q[i], mem[a + 24'(i)]);
        end else begin
            check(8'(oe_seen), 8'h0);
        end
        check({read_active, 3'h0, lanes_oe}, 8'h0);
    endtask
    task automatic complete_run();
        if (error_cnt == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        sys_rst = 1'b1;
        proto_sel = 2'b00;
        load_en = 1'b0;
        load_addr = 24'h0;
        load_data = 8'h0;
        void'($urandom(64435));
        repeat (3) @(posedge clk);
        #1;
        sys_rst = 1'b0;
        check({read_active, 3'h0, lanes_oe}, 8'h0);
        repeat (6) @(posedge clk);
        for (int p = 0; p < 4; p++) begin
            foreach (cmds[k]) run(p, cmds[k], 24'($urandom));
        end
        run(0, 8'h03, 24'hfffffe);
        run(2, 8'heb, 24'hffffff);
        complete_run();
    end
endmodule
